// ==== rtl/rtw_pkg.sv ====
// Purpose: Shared constants for the reload timer block with watchdog.
// Assumes: 25 MHz system clock; 8-bit register port with byte offsets.
// Notes: Offsets are the low byte of the register address.
package rtw_pkg;
	localparam logic [7:0] TIMER45_MODE_OFS = 8'hF8;
	localparam logic [7:0] INT_CTRL_OFS = 8'hFE;
	localparam logic [7:0] TIMER_CTRL_OFS = 8'hFF;
	localparam logic [7:0] SERIAL_MODE_OFS = 8'hF6;
	localparam logic [7:0] TIMER1_OFS = 8'hF0;
	localparam logic [7:0] TIMER2_OFS = 8'hF1;
	localparam logic [7:0] TIMER3_OFS = 8'hF2;
	localparam logic [7:0] TIMER4_OFS = 8'hF9;
	localparam logic [7:0] TIMER5_OFS = 8'hFA;
	localparam int TCR_SRC1_BIT = 2;
	localparam int TCR_SRC2_BIT = 3;
	localparam int TCR_SRC3_BIT = 4;
	localparam int TCR_T1_STOP_BIT = 5;
	localparam int TCR_T1_IE_BIT = 6;
	localparam int ICR_T2_IE_BIT = 4;
	localparam int M45_T5_OVF_BIT = 7;
	localparam int M45_MODE_LO_BIT = 4;
	localparam int SIO_ENABLE_BIT = 2;
	localparam int SIO_T3OUT_BIT = 4;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [7:0] TIMER_RESET = 8'hFF;
	localparam logic [1:0] DIV4_LAST = 2'h3;
	localparam int CLK_HZ = 25000000;
	localparam real INIT_DELAY_US = 12.5;
	localparam real HIZ_DELAY_US = 12.5;
	localparam int INIT_DELAY_CYC = int'($ceil(INIT_DELAY_US * CLK_HZ / 1.0e6));
	localparam int HIZ_DELAY_CYC = int'($ceil(HIZ_DELAY_US * CLK_HZ / 1.0e6));
	localparam logic [1:0] MODE_TIMER = 2'h0;
	localparam logic [1:0] MODE_PULSE = 2'h1;
	localparam logic [1:0] MODE_EVENT = 2'h2;
	localparam logic [1:0] MODE_WIDTH = 2'h3;
	typedef enum logic [1:0] {
		RTW_RUN = 2'h0,
		RTW_STOP_CHAIN = 2'h1
	} rtw_mode_t;
endpackage : rtw_pkg

// ==== rtl/rtw_down_counter.sv ====
// Purpose: One 8-bit reload down-counter with reload latch.
// Assumes: Count pulse is a one-cycle enable in the system clock domain.
// Notes: A write loads latch and counter together.
`timescale 1ns/10ps
module rtw_down_counter #(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	// Control
	input wire logic count_i,
	input wire logic wr_i,
	input wire logic [WIDTH-1:0] wdata_i,
	// Status
	output logic [WIDTH-1:0] value_o,
	output logic underflow_o
);
	typedef struct packed {
		logic [WIDTH-1:0] cnt;
		logic [WIDTH-1:0] latch;
		logic uf;
	} rtw_cnt_state_t;
	rtw_cnt_state_t st_r;
	rtw_cnt_state_t st_nxt;
	always_comb begin
		st_nxt = st_r;
		st_nxt.uf = 1'b0;
		if (wr_i) begin
			st_nxt.latch = wdata_i;
			st_nxt.cnt = wdata_i;
		end else if (count_i) begin
			if (st_r.cnt == '0) begin
				// Reload on the pulse after zero gives latch+1 pulses a period.
				st_nxt.cnt = st_r.latch;
				st_nxt.uf = 1'b1;
			end else begin
				st_nxt.cnt = st_r.cnt - 1'b1;
			end
		end
	end
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st_r <= '{cnt: '1, latch: '1, uf: 1'b0};
		end else begin
			st_r <= st_nxt;
		end
	end
	assign value_o = st_r.cnt;
	assign underflow_o = st_r.uf;
endmodule : rtw_down_counter

// ==== rtl/rtw_timers.sv ====
// Purpose: Five reload down-counters, stop-mode chain, timer 4/5 modes, watchdog.
// Assumes: Byte register port; count sources are one-cycle enables.
// Notes: Interrupt acceptance lies outside; this block only raises request flags.
//
// Contract
// - Each timer counts down and keeps an 8-bit reload latch of the last write.
// - A count pulse at zero reloads the latch instead of decrementing.
// - Period spans latch plus one count pulses.
// - Request flag rises on the reload pulse after zero.
// - Timer control bits 2, 3, 4 pick sources of timers 1, 2, 3.
// - Outside the stop chain, timer 1 counts while control bit 5 is 0, holds while 1.
// - Stop chains clock/4, timer 1, timer 2; ends on timer 2 flag or reset.
// - Mode 00: timer 4 counts clock/4, timer 5 its underflows; flag, reload, continue.
// - Mode 01: counter pin toggles each time timer reaches zero.
// - Mode 10: count only on rising edges of the counter pin.
// - Mode 11: count clock/4 while pin low; timer 5 overflow flag set.
// - Writing 0 to mode register bit 7 clears timer 5 overflow flag.
// - Serial mode bit 4 drives timer 3 overflow halved onto its pin.
// - Watchdog chosen by mode bits 5:4 = 01 with pin wired to reset.
// - In watchdog use each timer 5 write forces halving stage output to 1.
// - Mode bits 4, 5, 6 clear 12.5 to 15.0 us after reset.
// - Unrefreshed timer 5 overflow drives counter pin low until reset.
// - Counter pin goes high impedance 12.5 to 17.5 us after reset.
// - With serial enabled, timer 3 raises no interrupt request.
`timescale 1ns/10ps
module rtw_timers #(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	// Register port
	input wire logic reg_wr_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	// External count sources, stop request and serial request
	input wire logic ext_src1_i,
	input wire logic ext_src2_i,
	input wire logic ext_src3_i,
	input wire logic stop_instruction_i,
	input wire logic serial_irq_i,
	// Counter pin
	input wire logic counter_pin_i,
	output logic counter_pin_o,
	output logic counter_pin_oe_o,
	// Outputs
	output logic timer3_half_output_pin_o,
	output logic t1_irq_o,
	output logic t2_irq_o,
	output logic t3_irq_o,
	output logic t4_irq_o,
	output logic stop_chain_o
);
	localparam int INIT_W = $clog2(rtw_pkg::INIT_DELAY_CYC + 2);
	localparam logic [INIT_W-1:0] INIT_LAST = INIT_W'(rtw_pkg::INIT_DELAY_CYC);
	localparam logic [INIT_W-1:0] HIZ_LAST = INIT_W'(rtw_pkg::HIZ_DELAY_CYC);

	typedef struct packed {
		logic [7:0] tcr;
		logic [7:0] icr;
		logic [7:0] m45;
		logic [7:0] sio;
		logic [1:0] div4;
		logic [2:0] src_s1;
		logic [2:0] src_s2;
		logic [2:0] src_p;
		logic pin_s1;
		logic pin_s2;
		logic pin_p;
		logic pin_out;
		logic pin_oe;
		logic wd_trip;
		logic t5_half;
		logic t3_half;
		logic h3_out;
		logic [3:0] irq;
		logic [INIT_W-1:0] init_cnt;
		logic init_done;
		rtw_pkg::rtw_mode_t mode;
		logic [7:0] rdata;
	} rtw_state_t;
	rtw_state_t st_r;
	rtw_state_t st_nxt;

	logic [4:0] cnt_en;
	logic [4:0] cnt_wr;
	logic [4:0] uf;
	logic [WIDTH-1:0] val [5];
	logic [7:0] t_ofs [5];
	logic tick4;
	logic [2:0] src_edge;
	logic pin_rise;
	logic [1:0] m45_mode;
	logic wd_mode;

	assign t_ofs[0] = rtw_pkg::TIMER1_OFS;
	assign t_ofs[1] = rtw_pkg::TIMER2_OFS;
	assign t_ofs[2] = rtw_pkg::TIMER3_OFS;
	assign t_ofs[3] = rtw_pkg::TIMER4_OFS;
	assign t_ofs[4] = rtw_pkg::TIMER5_OFS;

	assign tick4 = (st_r.div4 == rtw_pkg::DIV4_LAST);
	assign src_edge = st_r.src_s2 & ~st_r.src_p;
	assign pin_rise = st_r.pin_s2 & ~st_r.pin_p;
	assign m45_mode = st_r.m45[rtw_pkg::M45_MODE_LO_BIT +: 2];
	assign wd_mode = (m45_mode == rtw_pkg::MODE_PULSE);

	genvar gi;
	generate
		for (gi = 0; gi < 5; gi++) begin : g_tmr
			assign cnt_wr[gi] = reg_wr_i && (reg_addr_i == t_ofs[gi]);
			rtw_down_counter #(
				.WIDTH(WIDTH)
			) u_cnt (
				.clk_i(clk_i),
				.reset_n_i(reset_n_i),
				.count_i(cnt_en[gi]),
				.wr_i(cnt_wr[gi]),
				.wdata_i(reg_wdata_i[WIDTH-1:0]),
				.value_o(val[gi]),
				.underflow_o(uf[gi])
			);
		end
	endgenerate

	// Count enables; sources come from the clock/4 divider, synchronised pins or the underflow of the timer below.
	always_comb begin
		cnt_en = '0;
		if (st_r.mode == rtw_pkg::RTW_STOP_CHAIN) begin
			// Source select bits are ignored while chained.
			cnt_en[0] = tick4;
			cnt_en[1] = uf[0];
		end else begin
			cnt_en[0] = (st_r.tcr[rtw_pkg::TCR_SRC1_BIT] ? src_edge[0] : tick4)
				&& !st_r.tcr[rtw_pkg::TCR_T1_STOP_BIT];
			cnt_en[1] = st_r.tcr[rtw_pkg::TCR_SRC2_BIT] ? uf[0] : tick4;
			cnt_en[2] = st_r.tcr[rtw_pkg::TCR_SRC3_BIT] ? src_edge[2] : tick4;
		end
		case (m45_mode)
			rtw_pkg::MODE_TIMER: begin
				cnt_en[3] = tick4;
			end
			rtw_pkg::MODE_PULSE: begin
				cnt_en[3] = tick4;
			end
			rtw_pkg::MODE_EVENT: begin
				// The pin passes two flip-flops first, so an edge is seen late but clean.
				cnt_en[3] = pin_rise;
			end
			rtw_pkg::MODE_WIDTH: begin
				cnt_en[3] = tick4 && !st_r.pin_s2;
			end
			default: begin
				cnt_en[3] = 1'b0;
			end
		endcase
		// Timer 5 extends timer 4 as the upper stage of the pair.
		cnt_en[4] = uf[3];
	end

	always_comb begin
		st_nxt = st_r;
		st_nxt.div4 = st_r.div4 + 2'h1;
		st_nxt.src_s1 = {ext_src3_i, ext_src2_i, ext_src1_i};
		st_nxt.src_s2 = st_r.src_s1;
		st_nxt.src_p = st_r.src_s2;
		st_nxt.pin_s1 = counter_pin_i;
		st_nxt.pin_s2 = st_r.pin_s1;
		st_nxt.pin_p = st_r.pin_s2;
		st_nxt.irq = st_r.irq;
		if (uf[0]) begin
			st_nxt.irq[0] = 1'b1;
		end
		if (uf[1]) begin
			st_nxt.irq[1] = 1'b1;
		end
		if (st_r.sio[rtw_pkg::SIO_ENABLE_BIT]) begin
			if (serial_irq_i) begin
				st_nxt.irq[2] = 1'b1;
			end
		end else if (uf[2]) begin
			st_nxt.irq[2] = 1'b1;
		end
		if (uf[4]) begin
			st_nxt.irq[3] = 1'b1;
		end
		if (uf[2]) begin
			st_nxt.t3_half = ~st_r.t3_half;
		end
		// Register writes.
		if (reg_wr_i) begin
			case (reg_addr_i)
				rtw_pkg::TIMER_CTRL_OFS: begin
					st_nxt.tcr = reg_wdata_i;
				end
				rtw_pkg::INT_CTRL_OFS: begin
					st_nxt.icr = reg_wdata_i;
				end
				rtw_pkg::SERIAL_MODE_OFS: begin
					st_nxt.sio = reg_wdata_i;
				end
				rtw_pkg::TIMER45_MODE_OFS: begin
					st_nxt.m45[6:0] = reg_wdata_i[6:0];
					if (!reg_wdata_i[rtw_pkg::M45_T5_OVF_BIT]) begin
						st_nxt.m45[rtw_pkg::M45_T5_OVF_BIT] = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end
		// Set wins over a same-cycle software clear.
		if (uf[4] && m45_mode == rtw_pkg::MODE_WIDTH) begin
			st_nxt.m45[rtw_pkg::M45_T5_OVF_BIT] = 1'b1;
		end
		// Pulse output and watchdog on the counter pin.
		if (uf[4]) begin
			st_nxt.t5_half = ~st_r.t5_half;
		end
		if (wd_mode && cnt_wr[4]) begin
			st_nxt.t5_half = 1'b1;
		end
		if (wd_mode && uf[4] && st_r.t5_half) begin
			st_nxt.wd_trip = 1'b1;
		end
		st_nxt.pin_out = st_nxt.t5_half && !st_nxt.wd_trip;
		// Gate with the next enable so the pin drops in the same cycle as the bit.
		st_nxt.h3_out = st_nxt.t3_half && st_nxt.sio[rtw_pkg::SIO_T3OUT_BIT];
		if (st_r.init_done) begin
			st_nxt.pin_oe = wd_mode || st_nxt.wd_trip;
		end
		// Post-reset initialisation of the mode bits and the pin.
		if (!st_r.init_done) begin
			st_nxt.init_cnt = st_r.init_cnt + INIT_W'(1);
			if (st_r.init_cnt == HIZ_LAST) begin
				st_nxt.pin_oe = 1'b0;
			end
			if (st_r.init_cnt == INIT_LAST) begin
				st_nxt.m45[6:4] = 3'h0;
				st_nxt.init_done = 1'b1;
			end
		end
		// Stop-mode chain.
		case (st_r.mode)
			rtw_pkg::RTW_RUN: begin
				if (stop_instruction_i) begin
					st_nxt.mode = rtw_pkg::RTW_STOP_CHAIN;
				end
			end
			rtw_pkg::RTW_STOP_CHAIN: begin
				if (st_r.irq[1]) begin
					st_nxt.mode = rtw_pkg::RTW_RUN;
				end
			end
			default: st_nxt.mode = rtw_pkg::RTW_RUN;
		endcase
		// Read data, registered; timer offsets read the live count.
		st_nxt.rdata = 8'h00;
		// A timer read shows the count, not the latch; software cannot read the latch back.
		case (reg_addr_i)
			rtw_pkg::TIMER_CTRL_OFS: begin
				st_nxt.rdata = st_r.tcr;
			end
			rtw_pkg::INT_CTRL_OFS: begin
				st_nxt.rdata = st_r.icr;
			end
			rtw_pkg::SERIAL_MODE_OFS: begin
				st_nxt.rdata = st_r.sio;
			end
			rtw_pkg::TIMER45_MODE_OFS: begin
				st_nxt.rdata = st_r.m45;
			end
			rtw_pkg::TIMER1_OFS: begin
				st_nxt.rdata = 8'(val[0]);
			end
			rtw_pkg::TIMER2_OFS: begin
				st_nxt.rdata = 8'(val[1]);
			end
			rtw_pkg::TIMER3_OFS: begin
				st_nxt.rdata = 8'(val[2]);
			end
			rtw_pkg::TIMER4_OFS: begin
				st_nxt.rdata = 8'(val[3]);
			end
			rtw_pkg::TIMER5_OFS: begin
				st_nxt.rdata = 8'(val[4]);
			end
			default: begin
				st_nxt.rdata = 8'h00;
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st_r <= '{
				tcr: rtw_pkg::REG_RESET,
				icr: rtw_pkg::REG_RESET,
				m45: rtw_pkg::REG_RESET,
				sio: rtw_pkg::REG_RESET,
				div4: 2'h0,
				src_s1: 3'h0,
				src_s2: 3'h0,
				src_p: 3'h0,
				pin_s1: 1'b1,
				pin_s2: 1'b1,
				pin_p: 1'b1,
				pin_out: 1'b0,
				pin_oe: 1'b1,
				wd_trip: 1'b0,
				t5_half: 1'b0,
				t3_half: 1'b0,
				h3_out: 1'b0,
				irq: 4'h0,
				init_cnt: '0,
				init_done: 1'b0,
				mode: rtw_pkg::RTW_RUN,
				rdata: 8'h00
			};
		end else begin
			st_r <= st_nxt;
		end
	end

	// Request flags are reported here; clearing them belongs to the interrupt logic.
	assign reg_rdata_o = st_r.rdata;
	assign counter_pin_o = st_r.pin_out;
	assign counter_pin_oe_o = st_r.pin_oe;
	assign timer3_half_output_pin_o = st_r.h3_out;
	assign t1_irq_o = st_r.irq[0];
	assign t2_irq_o = st_r.irq[1];
	assign t3_irq_o = st_r.irq[2];
	assign t4_irq_o = st_r.irq[3];
	assign stop_chain_o = (st_r.mode == rtw_pkg::RTW_STOP_CHAIN);
endmodule : rtw_timers

// ==== bench/rtw_props.sv ====
// Purpose: Port-level checker for the reload timer block.
// Assumes: Sees only the top module ports; serial mode bits shadowed from writes.
// Notes: One clock domain, so default clocking and disable are used.
`timescale 1ns/10ps
module rtw_props (
	// Clock, reset and register port
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic reg_wr_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic [7:0] reg_rdata_o,
	// Requests and outputs
	input wire logic stop_instruction_i,
	input wire logic serial_irq_i,
	input wire logic counter_pin_oe_o,
	input wire logic timer3_half_output_pin_o,
	input wire logic t1_irq_o,
	input wire logic t2_irq_o,
	input wire logic t3_irq_o,
	input wire logic stop_chain_o
);
	logic [1:0] sio_r;
	logic [9:0] age_r;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sio_r <= 2'h0;
			age_r <= 10'h000;
		end else begin
			if (reg_wr_i && reg_addr_i == rtw_pkg::SERIAL_MODE_OFS) begin
				sio_r <= {reg_wdata_i[rtw_pkg::SIO_T3OUT_BIT], reg_wdata_i[rtw_pkg::SIO_ENABLE_BIT]};
			end
			if (age_r != 10'h3FF) begin
				age_r <= age_r + 10'h001;
			end
		end
	end
	sequence tcr_wr_s;
		reg_wr_i && reg_addr_i == rtw_pkg::TIMER_CTRL_OFS;
	endsequence
	sequence tcr_rd_s;
		!reg_wr_i && reg_addr_i == rtw_pkg::TIMER_CTRL_OFS;
	endsequence
	stop_readback_a: assert property (tcr_wr_s ##1 tcr_rd_s |=>
		reg_rdata_o[5] == $past(reg_wdata_i[5], 2)) else $error("stop bit readback wrong");
	irq_sticky_a: assert property (t1_irq_o |=> t1_irq_o)
		else $error("timer 1 flag dropped");
	irq_hold_a: assert property ($rose(t2_irq_o) |=> t2_irq_o [*4])
		else $error("timer 2 flag dropped");
	chain_enter_a: assert property (stop_instruction_i && !t2_irq_o |-> ##[1:2] stop_chain_o)
		else $error("stop chain not entered");
	chain_leave_a: assert property ($rose(t2_irq_o) |-> ##[0:2] !stop_chain_o)
		else $error("stop chain not left");
	serial_mute_a: assert property (sio_r[0] && !t3_irq_o && !serial_irq_i &&
		!$past(serial_irq_i) |=> !t3_irq_o) else $error("timer 3 flag with serial on");
	half_gate_a: assert property (!sio_r[1] |-> !timer3_half_output_pin_o)
		else $error("timer 3 half output not gated");
	pin_hold_a: assert property (age_r < 10'h12C |-> counter_pin_oe_o)
		else $error("counter pin released early");
	unmapped_zero_a: assert property (reg_addr_i == 8'h00 |=> reg_rdata_o == 8'h00)
		else $error("unmapped read not zero");
endmodule : rtw_props

// ==== bench/rtw_pin_src.sv ====
// Purpose: Pulse source with pull-up standing on the counter pin.
// Assumes: The block drives the pin whenever its enable is high.
// Notes: Drive changes just after a rising edge.
`timescale 1ns/10ps
module rtw_pin_src (
	// Clock
	input wire logic clk_i,
	// Block side of the pin
	input wire logic pin_drv_i,
	input wire logic pin_oe_i,
	// Resolved pin level
	output logic pin_o
);
	logic ext_en;
	initial ext_en = 1'b0;
	// A released pin rises to the pull-up, as the reset input it feeds would.
	assign pin_o = pin_oe_i ? pin_drv_i : !ext_en;
	task automatic hold_low(input logic on);
		@(posedge clk_i);
		ext_en <= on;
	endtask : hold_low
	task automatic pulses(input int n, input int gap);
		repeat (n) begin
			hold_low(1'b1);
			repeat (gap) @(posedge clk_i);
			hold_low(1'b0);
			repeat (gap) @(posedge clk_i);
		end
	endtask : pulses
endmodule : rtw_pin_src

// ==== bench/reload_timers_with_watchdog_bench.sv ====
// Purpose: Self-checking bench for the reload timer block.
// Assumes: Read data answers one cycle after the address.
// Notes: External sources toggle every cycle; flags are sticky, so scenarios reset first.
`timescale 1ns/10ps
module reload_timers_with_watchdog_bench;
	logic clk_i, reset_n_i, wr, pin, s1, s2, s3, stop_instruction, sirq;
	logic po, poe, h3, i1, i2, i3, i4, sc;
	logic [7:0] adr, wd, rd;
	int fails, checks;
	rtw_timers i_dut (.clk_i, .reset_n_i, .reg_wr_i(wr), .reg_addr_i(adr), .reg_wdata_i(wd),
		.reg_rdata_o(rd), .ext_src1_i(s1), .ext_src2_i(s2), .ext_src3_i(s3),
		.stop_instruction_i(stop_instruction), .serial_irq_i(sirq), .counter_pin_i(pin), .counter_pin_o(po),
		.counter_pin_oe_o(poe), .timer3_half_output_pin_o(h3), .t1_irq_o(i1), .t2_irq_o(i2),
		.t3_irq_o(i3), .t4_irq_o(i4), .stop_chain_o(sc));
	rtw_pin_src u_src (.clk_i, .pin_drv_i(po), .pin_oe_i(poe), .pin_o(pin));
	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end
	always @(posedge clk_i) {s1, s2, s3} <= ~{s1, s2, s3};
	task automatic chk(input string n, input logic [7:0] g, input logic [7:0] e);
		checks++;
		if (g !== e) begin
			fails++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
		@(negedge clk_i);
	endtask : cyc
	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		{wr, adr, wd} <= {1'b1, a, d};
		@(posedge clk_i);
		wr <= 1'b0;
	endtask : wreg
	task automatic rchk(input string n, input logic [7:0] a, input logic [7:0] m,
		input logic [7:0] e);
		@(posedge clk_i);
		adr <= a;
		cyc(1);
		chk(n, rd & m, e);
	endtask : rchk
	task automatic do_reset(input int w);
		@(posedge clk_i);
		reset_n_i <= 1'b0;
		repeat (16) @(posedge clk_i);
		reset_n_i <= 1'b1;
		cyc(w);
	endtask : do_reset
	task automatic t_init;
		do_reset(0);
		wreg(rtw_pkg::TIMER45_MODE_OFS, 8'h70);
		cyc(280);
		chk("pin enable", {7'h00, poe}, 8'h01);
		cyc(60);
		chk("pin enable", {7'h00, poe}, 8'h00);
		rchk("mode bits", rtw_pkg::TIMER45_MODE_OFS, 8'h70, 8'h00);
	endtask : t_init
	task automatic t_period;
		do_reset(320);
		wreg(rtw_pkg::TIMER4_OFS, 8'h03);
		wreg(rtw_pkg::TIMER5_OFS, 8'h01);
		wreg(rtw_pkg::TIMER45_MODE_OFS, 8'h00);
		cyc(20);
		chk("pair early", {7'h00, i4}, 8'h00);
		cyc(30);
		chk("pair period", {7'h00, i4}, 8'h01);
	endtask : t_period
	task automatic t_event;
		do_reset(320);
		wreg(rtw_pkg::TIMER45_MODE_OFS, 8'h20);
		wreg(rtw_pkg::TIMER4_OFS, 8'h01);
		wreg(rtw_pkg::TIMER5_OFS, 8'h00);
		u_src.pulses(1, 6);
		cyc(8);
		chk("event one", {7'h00, i4}, 8'h00);
		u_src.pulses(1, 6);
		cyc(8);
		chk("event two", {7'h00, i4}, 8'h01);
	endtask : t_event
	task automatic t_width;
		do_reset(320);
		wreg(rtw_pkg::TIMER4_OFS, 8'h00);
		wreg(rtw_pkg::TIMER5_OFS, 8'h00);
		wreg(rtw_pkg::TIMER45_MODE_OFS, 8'h30);
		u_src.hold_low(1'b1);
		cyc(20);
		u_src.hold_low(1'b0);
		cyc(6);
		rchk("overflow", rtw_pkg::TIMER45_MODE_OFS, 8'h80, 8'h80);
		wreg(rtw_pkg::TIMER45_MODE_OFS, 8'h30);
		cyc(40);
		rchk("overflow", rtw_pkg::TIMER45_MODE_OFS, 8'h80, 8'h00);
	endtask : t_width
	task automatic t_watchdog;
		do_reset(320);
		wreg(rtw_pkg::TIMER4_OFS, 8'h03);
		wreg(rtw_pkg::TIMER5_OFS, 8'h01);
		wreg(rtw_pkg::TIMER45_MODE_OFS, 8'h10);
		repeat (10) begin
			cyc(10);
			wreg(rtw_pkg::TIMER5_OFS, 8'h01);
		end
		cyc(1);
		chk("pin refreshed", {6'h00, poe, po}, 8'h03);
		cyc(60);
		chk("pin tripped", {6'h00, poe, po}, 8'h02);
		cyc(200);
		chk("pin held", {6'h00, poe, po}, 8'h02);
	endtask : t_watchdog
	task automatic t_stop;
		do_reset(320);
		wreg(rtw_pkg::TIMER_CTRL_OFS, 8'h20);
		rchk("stop bit", rtw_pkg::TIMER_CTRL_OFS, 8'h20, 8'h20);
		wreg(rtw_pkg::TIMER1_OFS, 8'h02);
		cyc(40);
		rchk("timer 1 held", rtw_pkg::TIMER1_OFS, 8'hFF, 8'h02);
		wreg(rtw_pkg::TIMER_CTRL_OFS, 8'h00);
		wreg(rtw_pkg::INT_CTRL_OFS, 8'h00);
		wreg(rtw_pkg::TIMER2_OFS, 8'h01);
		@(posedge clk_i);
		stop_instruction <= 1'b1;
		@(posedge clk_i);
		stop_instruction <= 1'b0;
		cyc(2);
		chk("chain on", {7'h00, sc}, 8'h01);
		cyc(60);
		chk("chain off", {6'h00, sc, i2}, 8'h01);
	endtask : t_stop
	task automatic t_serial;
		logic hi, lo;
		{hi, lo} = 2'h0;
		do_reset(320);
		wreg(rtw_pkg::SERIAL_MODE_OFS, 8'h14);
		wreg(rtw_pkg::TIMER3_OFS, 8'h00);
		repeat (100) begin
			cyc(0);
			{hi, lo} = {hi | h3, lo | !h3};
		end
		chk("half output", {6'h00, hi, lo}, 8'h03);
		chk("timer 3 silent", {7'h00, i3}, 8'h00);
		@(posedge clk_i);
		sirq <= 1'b1;
		@(posedge clk_i);
		sirq <= 1'b0;
		cyc(3);
		chk("serial slot", {7'h00, i3}, 8'h01);
		rchk("unmapped", 8'h00, 8'hFF, 8'h00);
	endtask : t_serial
	task automatic report_and_stop;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : report_and_stop
	initial begin
		{wr, stop_instruction, sirq, s1, s2, s3, reset_n_i, adr, wd} = '0;
		{fails, checks} = '0;
		t_init();
		t_period();
		t_event();
		t_width();
		t_watchdog();
		t_stop();
		t_serial();
		report_and_stop();
	end
	initial begin
		repeat (20000) @(posedge clk_i);
		fails++;
		report_and_stop();
	end
endmodule : reload_timers_with_watchdog_bench
bind rtw_timers rtw_props u_props (.clk_i, .reset_n_i, .reg_wr_i, .reg_addr_i, .reg_wdata_i,
	.reg_rdata_o, .stop_instruction_i, .serial_irq_i, .counter_pin_oe_o,
	.timer3_half_output_pin_o, .t1_irq_o, .t2_irq_o, .t3_irq_o, .stop_chain_o);
